// [ivr_core.sv]
// interrupt vectors, handler return, user opcodes and position event replies
// What this block does
// - opcode 37 stores handler address (value) for interrupt number (type).
// - redefining a vector overwrites the stored handler address.
// - a taken interrupt jumps to its stored handler address.
// - opcode 38 from a stored program ends handler, restoring accumulator, X, flags and PC.
// - opcodes 64..71 reply status 100 with a user-defined value.
// - opcode 138 works only in direct mode; ignored in stored programs.
// - opcode 138 replies at once: status 100, code 8A, mask in byte 0.
// - value of 138 is a motor mask; only bit 0, host sends 1.
// - type 0 arms the event for the next move command only.
// - type 1 keeps the event armed for every later move command.
// - target reached after a move issued while armed sends status 128, code 8A, mask reply.
// - enable with number 255 turns global interrupt handling on.
// - disable with number 255 turns global interrupt handling off.
`timescale 1ns/10ps
module ivr_core
  import ivr_pkg::*;
#(
  parameter int NUM_IRQ = 16,
  parameter int PC_W = 16,
  parameter int DATA_W = 32,
  parameter int FLAG_W = 8
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire logic [7:0] cmdOpcode,
  input wire logic [7:0] cmdType,
  input wire logic [31:0] cmdValue,
  input wire logic directMode,
  input wire logic [31:0] userValue,
  input wire logic progRun,
  input wire logic [NUM_IRQ-1:0] irqReq,
  input wire logic [PC_W-1:0] curPc,
  input wire logic [DATA_W-1:0] curAccu,
  input wire logic [DATA_W-1:0] curX,
  input wire logic [FLAG_W-1:0] curFlags,
  input wire logic moveIssued,
  input wire logic posReached,
  output logic jumpValid,
  output logic [PC_W-1:0] jumpPc,
  output logic restoreValid,
  output logic [DATA_W-1:0] restoreAccu,
  output logic [DATA_W-1:0] restoreX,
  output logic [FLAG_W-1:0] restoreFlags,
  output logic [NUM_IRQ-1:0] irqAck,
  output logic inHandler,
  output logic intGlobalEn,
  output logic posArmed,
  output logic replyValid,
  output logic [7:0] replyStatus,
  output logic [7:0] replyCmd,
  output logic [31:0] replyValue
);
  localparam int IDX_W = $clog2(NUM_IRQ);

  ivr_mode_t mode_r;
  logic [NUM_IRQ-1:0] definedMask;
  logic [NUM_IRQ*PC_W-1:0] entryFlat;
  logic [NUM_IRQ-1:0] eligible;
  logic [IDX_W-1:0] pickIdx;
  logic pickAny;
  logic [PC_W-1:0] takeAddr;
  logic vecWr, retTake, take, directCmd, userFn, posReq, immReply;
  logic armCmd;
  logic persist_r, watch_r, evtPend_r;
  logic [7:0] mask_r;
  logic [PC_W-1:0] savedPc_r;

  assign directCmd = cmdValid && directMode;
  assign vecWr = cmdValid && cmdOpcode == OPC_DEFINE_VECTOR
    && 32'(cmdType) < NUM_IRQ;
  // return only acts on a stored-program command inside a live handler; progRun is not checked
  assign retTake = cmdValid && !directMode && cmdOpcode == OPC_RETURN
    && inHandler;
  assign userFn = directCmd && cmdOpcode >= OPC_USER_FIRST
    && cmdOpcode <= OPC_USER_LAST;
  assign posReq = directCmd && cmdOpcode == OPC_POS_EVENT;
  assign armCmd = posReq && (cmdType == EVT_TYPE_SINGLE
    || cmdType == EVT_TYPE_PERSIST);
  assign immReply = userFn || posReq || (directCmd
    && (cmdOpcode == OPC_DEFINE_VECTOR || cmdOpcode == OPC_RETURN));
  assign eligible = irqReq & definedMask;

  ivr_vector_table #(.NUM_IRQ(NUM_IRQ), .PC_W(PC_W), .IDX_W(IDX_W)) uTable
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wrEn(vecWr),
    .wrIdx(cmdType[IDX_W-1:0]),
    .wrAddr(cmdValue[PC_W-1:0]),
    .definedMask(definedMask),
    .entryFlat(entryFlat)
  );

  // lowest number wins when several interrupts are pending
  always_comb
  begin
    pickIdx = '0;
    pickAny = 1'b0;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (eligible[i])
      begin
        pickIdx = IDX_W'(i);
        pickAny = 1'b1;
      end
    end
  end

  assign takeAddr = entryFlat[pickIdx*PC_W +: PC_W];
  // taken only between instructions so no command races the switch
  assign take = intGlobalEn && !inHandler && progRun && pickAny
    && !cmdValid;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      intGlobalEn <= 1'b0;
    else if (cmdValid && cmdOpcode == OPC_IRQ_ENABLE
      && cmdType == IRQ_GLOBAL)
      intGlobalEn <= 1'b1;
    else if (cmdValid && cmdOpcode == OPC_IRQ_DISABLE
      && cmdType == IRQ_GLOBAL)
      intGlobalEn <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      mode_r <= IVR_RUN;
      inHandler <= 1'b0;
    end
    else
    begin
      case (mode_r)
        IVR_RUN:
          if (take)
          begin
            mode_r <= IVR_HANDLER;
            inHandler <= 1'b1;
          end
        IVR_HANDLER:
          if (retTake)
          begin
            mode_r <= IVR_RUN;
            inHandler <= 1'b0;
          end
        default:
        begin
          mode_r <= IVR_RUN;
          inHandler <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      savedPc_r <= '0;
      restoreAccu <= '0;
      restoreX <= '0;
      restoreFlags <= '0;
    end
    else if (take)
    begin
      savedPc_r <= curPc;
      restoreAccu <= curAccu;
      restoreX <= curX;
      restoreFlags <= curFlags;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      jumpValid <= 1'b0;
      jumpPc <= '0;
      restoreValid <= 1'b0;
      irqAck <= '0;
    end
    else
    begin
      jumpValid <= take || retTake;
      jumpPc <= take ? takeAddr : savedPc_r;
      restoreValid <= retTake;
      irqAck <= take ? (NUM_IRQ'(1) << pickIdx) : '0;
    end
  end

  // event arming; a single-shot arm is spent by the first move it sees
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      posArmed <= 1'b0;
      persist_r <= 1'b0;
      mask_r <= MASK_RESET;
    end
    else if (armCmd)
    begin
      posArmed <= 1'b1;
      persist_r <= cmdType == EVT_TYPE_PERSIST;
      mask_r <= cmdValue[7:0];
    end
    else if (moveIssued && posArmed && !persist_r)
      posArmed <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      watch_r <= 1'b0;
    else if (moveIssued && posArmed)
      watch_r <= 1'b1;
    else if (posReached)
      watch_r <= 1'b0;
  end

  // a new arrival wins over the cycle that sends the pending event
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      evtPend_r <= 1'b0;
    else if (posReached && watch_r)
      evtPend_r <= 1'b1;
    else if (!immReply)
      evtPend_r <= 1'b0;
  end

  // immediate replies go first; the event waits one cycle behind them
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      replyValid <= 1'b0;
      replyStatus <= '0;
      replyCmd <= '0;
      replyValue <= '0;
    end
    else if (immReply)
    begin
      replyValid <= 1'b1;
      replyStatus <= STATUS_OK;
      replyCmd <= cmdOpcode;
      replyValue <= userFn ? userValue
        : posReq ? {VALUE_UPPER_ZERO, cmdValue[7:0]} : '0;
    end
    else if (evtPend_r)
    begin
      replyValid <= 1'b1;
      replyStatus <= STATUS_POS_REACHED;
      replyCmd <= OPC_POS_EVENT;
      replyValue <= {VALUE_UPPER_ZERO, mask_r};
    end
    else
      replyValid <= 1'b0;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_enter;
    take;
  endsequence
  sequence s_jump_to(logic [PC_W-1:0] a);
    jumpValid && !restoreValid && jumpPc == a;
  endsequence

  define_vector_store_a: assert property (vecWr |=> definedMask[$past(cmdType[IDX_W-1:0])]
    ) else $error("vector not marked defined");
  define_vector_over_a: assert property (vecWr |=>
    entryFlat[$past(cmdType[IDX_W-1:0])*PC_W +: PC_W]
      == $past(cmdValue[PC_W-1:0])) else $error("vector not overwritten");
  handler_jump_a: assert property (s_enter |=> s_jump_to($past(takeAddr)))
    else $error("handler entry address wrong");
  handler_ret_a: assert property (retTake |=> restoreValid && jumpValid
    && jumpPc == $past(savedPc_r) && !inHandler) else $error("bad return");
  user_reply_a: assert property (userFn |=> replyValid
    && replyStatus == STATUS_OK && replyValue == $past(userValue))
    else $error("user opcode reply wrong");
  stored_138_a: assert property (cmdValid && !directMode
    && cmdOpcode == OPC_POS_EVENT && !moveIssued |=> $stable(posArmed))
    else $error("event armed from stored program");
  pos_ack_a: assert property (posReq |=> replyValid
    && replyStatus == STATUS_OK && replyCmd == OPC_POS_EVENT
    && replyValue == {VALUE_UPPER_ZERO, $past(cmdValue[7:0])})
    else $error("event request reply wrong");
  single_shot_a: assert property (posArmed && !persist_r && moveIssued
    && !armCmd |=> !posArmed && watch_r) else $error("single arm kept");
  persist_keep_a: assert property (posArmed && persist_r && moveIssued
    && !armCmd |=> posArmed [*2]) else $error("persistent arm lost");
  event_reply_a: assert property (posReached && watch_r |=>
    evtPend_r ##[0:4] (replyValid && replyStatus == STATUS_POS_REACHED
    && replyCmd == OPC_POS_EVENT && replyValue[7:0] == mask_r))
    else $error("position reached reply missing");
  global_on_a: assert property ($rose(jumpValid) && !restoreValid
    |-> $past(intGlobalEn)) else $error("handler entered while disabled");
  global_off_a: assert property (cmdValid && cmdOpcode == OPC_IRQ_DISABLE
    && cmdType == IRQ_GLOBAL |=> !intGlobalEn ##1 !(jumpValid && !restoreValid))
    else $error("handler entered after global disable");
  save_ctx_a: assert property (s_enter |=> restoreAccu == $past(curAccu)
    && restoreX == $past(curX) && restoreFlags == $past(curFlags))
    else $error("context not saved");
  undef_vec_a: assert property (irqReq != '0 && (irqReq & definedMask) == '0
    |=> !(jumpValid && !restoreValid)) else $error("jump without vector");
endmodule

// [ivr_pkg.sv]
// opcodes, reply codes and shared types of the vector and event-reply block
package ivr_pkg;
  localparam logic [7:0] OPC_DEFINE_VECTOR = 8'h25;
  localparam logic [7:0] OPC_RETURN = 8'h26;
  localparam logic [7:0] OPC_IRQ_ENABLE = 8'h19;
  localparam logic [7:0] OPC_IRQ_DISABLE = 8'h1a;
  localparam logic [7:0] OPC_USER_FIRST = 8'h40;
  localparam logic [7:0] OPC_USER_LAST = 8'h47;
  localparam logic [7:0] OPC_POS_EVENT = 8'h8a;
  localparam logic [7:0] IRQ_GLOBAL = 8'hff;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_POS_REACHED = 8'h80;
  localparam logic [7:0] EVT_TYPE_SINGLE = 8'h00;
  localparam logic [7:0] EVT_TYPE_PERSIST = 8'h01;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [23:0] VALUE_UPPER_ZERO = 24'h000000;
  typedef enum logic {IVR_RUN, IVR_HANDLER} ivr_mode_t;
endpackage

// [ivr_vector_table.sv]
// handler entry table: one address and one defined bit per interrupt number
`timescale 1ns/10ps
module ivr_vector_table
  import ivr_pkg::*;
#(
  parameter int NUM_IRQ = 16,
  parameter int PC_W = 16,
  parameter int IDX_W = $clog2(NUM_IRQ)
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [IDX_W-1:0] wrIdx,
  input wire logic [PC_W-1:0] wrAddr,
  output logic [NUM_IRQ-1:0] definedMask,
  output logic [NUM_IRQ*PC_W-1:0] entryFlat
);
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++)
    begin : gEntry
      always_ff @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          definedMask[g] <= 1'b0;
          entryFlat[g*PC_W +: PC_W] <= '0;
        end
        else if (wrEn && wrIdx == IDX_W'(g))
        begin
          // a second definition simply replaces the first
          definedMask[g] <= 1'b1;
          entryFlat[g*PC_W +: PC_W] <= wrAddr;
        end
      end
    end
  endgenerate
endmodule

// [ivr_host.sv]
// host model: presents one command frame per send pulse
`timescale 1ns/10ps
module ivr_host
  import ivr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic send,
  input wire logic [7:0] sOp,
  input wire logic [7:0] sType,
  input wire logic [31:0] sValue,
  input wire logic sDm,
  output logic cmdValid,
  output logic [7:0] cmdOpcode,
  output logic [7:0] cmdType,
  output logic [31:0] cmdValue,
  output logic directMode
);
  logic [47:0] last_r = '0;
  always_ff @(posedge clk_sys)
    if (send)
      last_r <= {sOp, sType, sValue};
  assign cmdValid = send;
  // idle fields show the inverse of the last frame, so stale data never matches
  assign {cmdOpcode, cmdType, cmdValue} = send ? {sOp, sType, sValue} : ~last_r;
  assign directMode = sDm;
endmodule

// [interrupt_vector_event_reply_bench.sv]
// self-checking bench of the vector and event-reply core
`timescale 1ns/10ps
module interrupt_vector_event_reply_bench
  import ivr_pkg::*;
;
  logic clk_sys = 0, rst_n = 0, send = 0, sDm = 0, progRun = 0;
  logic moveIssued = 0, posReached = 0, got;
  logic [7:0] sOp = 8'h00, sType = 8'h00, cmdOpcode, cmdType;
  logic [31:0] sValue = '0, userValue = '0, cmdValue;
  logic [31:0] curAccu = 32'h1234abcd, curX = 32'h0badf00d;
  logic [15:0] irqReq = '0, curPc = 16'h0123, jumpPc, irqAck;
  logic [7:0] curFlags = 8'h5a, restoreFlags, replyStatus, replyCmd;
  logic [31:0] restoreAccu, restoreX, replyValue;
  logic cmdValid, directMode, jumpValid, restoreValid, inHandler;
  logic intGlobalEn, posArmed, replyValid;
  logic [7:0] rOp[12], rTy[12];
  logic [31:0] rVa[12], rEx[12];
  logic rDm[12], rEv[12];
  int mismatches = 0, compares = 0;

  always #12.5 clk_sys = ~clk_sys;

  ivr_host i_host (.clk_sys(clk_sys), .send(send), .sOp(sOp), .sType(sType),
    .sValue(sValue), .sDm(sDm), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode),
    .cmdType(cmdType), .cmdValue(cmdValue), .directMode(directMode));

  ivr_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cmdValid(cmdValid),
    .cmdOpcode(cmdOpcode), .cmdType(cmdType), .cmdValue(cmdValue),
    .directMode(directMode), .userValue(userValue), .progRun(progRun),
    .irqReq(irqReq), .curPc(curPc), .curAccu(curAccu), .curX(curX),
    .curFlags(curFlags), .moveIssued(moveIssued), .posReached(posReached),
    .jumpValid(jumpValid), .jumpPc(jumpPc), .restoreValid(restoreValid),
    .restoreAccu(restoreAccu), .restoreX(restoreX),
    .restoreFlags(restoreFlags), .irqAck(irqAck), .inHandler(inHandler),
    .intGlobalEn(intGlobalEn), .posArmed(posArmed), .replyValid(replyValid),
    .replyStatus(replyStatus), .replyCmd(replyCmd), .replyValue(replyValue));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // returns 1ns after the taking edge, where the registered answer shows
  task cmd(input logic [7:0] op, ty, input logic [31:0] va, input logic dm);
    @(posedge clk_sys);
    #1;
    {send, sOp, sType, sValue, sDm} = {1'b1, op, ty, va, dm};
    @(posedge clk_sys);
    #1;
    send = 0;
  endtask

  task tick;
    @(posedge clk_sys);
    #1;
  endtask

  task waitRep(output logic g);
    g = 0;
    for (int i = 0; i < 6 && !g; i++)
    begin
      tick();
      if (replyValid === 1'b1)
        g = 1;
    end
  endtask

  // one move and one target hit; an event reply only when ev is set
  task mvRound(input logic ev, input logic armAfter);
    tick();
    moveIssued = 1;
    tick();
    moveIssued = 0;
    chk("posArmed", posArmed, armAfter);
    tick();
    posReached = 1;
    tick();
    posReached = 0;
    waitRep(got);
    chk("event", got, ev);
    if (ev)
    begin
      chk("evStatus", replyStatus, STATUS_POS_REACHED);
      chk("evCmd", replyCmd, OPC_POS_EVENT);
      chk("evValue", replyValue, 32'h1);
    end
  endtask

  initial
  begin
    #1000000;
    mismatches++;
    test_done();
  end

  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      rOp[i] = OPC_USER_FIRST + 8'(i);
      {rTy[i], rVa[i], rDm[i], rEv[i]} = {8'(i), 32'h0, 1'b1, 1'b1};
      rEx[i] = 32'h00a50000 + 32'(i);
    end
    {rOp[8], rTy[8], rVa[8], rDm[8], rEv[8], rEx[8]} =
      {OPC_DEFINE_VECTOR, 8'h05, 32'h9, 1'b1, 1'b1, 32'h0};
    {rOp[9], rTy[9], rVa[9], rDm[9], rEv[9], rEx[9]} =
      {OPC_POS_EVENT, EVT_TYPE_PERSIST, 32'h1, 1'b0, 1'b0, 32'h0};
    {rOp[10], rTy[10], rVa[10], rDm[10], rEv[10], rEx[10]} =
      {OPC_POS_EVENT, EVT_TYPE_PERSIST, 32'h1, 1'b1, 1'b1, 32'h1};
    {rOp[11], rTy[11], rVa[11], rDm[11], rEv[11], rEx[11]} =
      {OPC_RETURN, 8'hff, 32'h0, 1'b1, 1'b1, 32'h0};
    repeat (8) @(posedge clk_sys);
    #1;
    rst_n = 1;
    for (int i = 0; i < 12; i++)
    begin
      userValue = rEx[i];
      cmd(rOp[i], rTy[i], rVa[i], rDm[i]);
      chk("replyValid", replyValid, rEv[i]);
      if (rEv[i])
      begin
        chk("status", replyStatus, STATUS_OK);
        chk("cmd", replyCmd, rOp[i]);
        chk("value", replyValue, rEx[i]);
      end
    end
    chk("inHandler", inHandler, 1'b0);
    progRun = 1;
    cmd(OPC_DEFINE_VECTOR, 8'h00, 32'd50, 0);
    cmd(OPC_DEFINE_VECTOR, 8'h00, 32'd66, 0);
    cmd(OPC_IRQ_ENABLE, IRQ_GLOBAL, 32'h0, 0);
    chk("globalOn", intGlobalEn, 1'b1);
    irqReq = 16'h0008;
    tick();
    tick();
    chk("noVector", jumpValid, 1'b0);
    irqReq = 16'h0009;
    tick();
    irqReq = '0;
    chk("entry", jumpValid, 1'b1);
    chk("entryPc", jumpPc, 32'd66);
    chk("ack", irqAck, 32'h1);
    chk("inHandler", inHandler, 1'b1);
    chk("saveAccu", restoreAccu, 32'h1234abcd);
    chk("saveX", restoreX, 32'h0badf00d);
    curPc = 16'h0777;
    cmd(OPC_RETURN, 8'hff, 32'h0, 0);
    chk("retJump", {restoreValid, jumpValid}, 2'b11);
    chk("retPc", jumpPc, 32'h0123);
    chk("retFlags", restoreFlags, 32'h5a);
    chk("left", inHandler, 1'b0);
    cmd(OPC_IRQ_DISABLE, IRQ_GLOBAL, 32'h0, 0);
    chk("globalOff", intGlobalEn, 1'b0);
    irqReq = 16'h0001;
    tick();
    tick();
    chk("blocked", jumpValid | inHandler, 1'b0);
    irqReq = '0;
    rst_n = 0;
    repeat (8) tick();
    chk("rstOut", {replyValid, posArmed, inHandler, intGlobalEn}, 0);
    rst_n = 1;
    cmd(OPC_POS_EVENT, EVT_TYPE_SINGLE, 32'h1, 1);
    chk("armed", posArmed, 1'b1);
    mvRound(1'b1, 1'b0);
    mvRound(1'b0, 1'b0);
    cmd(OPC_POS_EVENT, EVT_TYPE_PERSIST, 32'h1, 1);
    mvRound(1'b1, 1'b1);
    mvRound(1'b1, 1'b1);
    test_done();
  end
endmodule
